// ===== core/mmrp_cfg.svh
`ifndef MMRP_CFG_SVH
`define MMRP_CFG_SVH

// APB register offsets
`define MMRP_OFF_REMAP 12'h000
`define MMRP_OFF_ASR 12'h004
`define MMRP_OFF_AASR 12'h008
`define MMRP_OFF_PPR 12'h00C
`define MMRP_OFF_FMR 12'h010
`define MMRP_OFF_FCR 12'h014
`define MMRP_OFF_FSR 12'h018
`define MMRP_OFF_MPU 12'h040
`define MMRP_MPU_WIN_MASK 12'hFC0

// Address map prefixes
`define MMRP_MB_ALIAS 12'h000
`define MMRP_MB_FLASH 12'h001
`define MMRP_MB_SRAM 12'h002
`define MMRP_PERIPH_NIB 4'hF
`define MMRP_SYS_PAGE 20'hFFFFF
`define MMRP_SYS_SLOT_LSB 9

// Protection area and peripheral protection fields
`define MMRP_PR_EN 0
`define MMRP_PR_WDENY 1
`define MMRP_PR_UDENY 2
`define MMRP_PR_SZ_LSB 4
`define MMRP_PR_SZ_MAX 4'hA
`define MMRP_PR_MASK 32'hFFFF_FCF7
`define MMRP_PR_MIN_MASK 32'hFFFF_FC00

// Abort status fields
`define MMRP_ASR_VALID 0
`define MMRP_ASR_SRC 1
`define MMRP_ASR_TYPE_LSB 2
`define MMRP_ASR_SIZE_LSB 4
`define MMRP_ASR_WRITE 6
`define MMRP_ASR_USER 7

// Flash sequencer fields
`define MMRP_FMR_WS_LSB 0
`define MMRP_FMR_IRQEN 2
`define MMRP_FCR_PAGE_LSB 8
`define MMRP_FSR_READY 0
`define MMRP_FSR_LOCKE 2
`define MMRP_FSR_CMDE 3
`define MMRP_FSR_LOCK_LSB 16

// Reset values
`define MMRP_RST_WORD 32'h0000_0000
`define MMRP_RST_FMR 3'h0
`define MMRP_RST_LOCKS 16'h0000

`endif

// ===== core/mmrp_flash_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmrp_cfg.svh"

module mmrp_flash_seq #(
  parameter int AW = 16,
  parameter int WB_WORDS = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Master access, request held until ack
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  output logic acc_ack,
  output logic [31:0] acc_rdata,
  // Configuration strobes
  input wire logic fmr_wr,
  input wire logic fcr_wr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] fmr_val,
  output logic [31:0] fsr_val,
  output logic irq,
  // Flash array
  output logic rd_en,
  output logic [AW-1:0] arr_addr,
  input wire logic [31:0] arr_rdata,
  output logic standby,
  output logic prog,
  output logic erase,
  output logic [9:0] page,
  input wire logic [$clog2(WB_WORDS)-1:0] wb_idx,
  output logic [31:0] wb_data
);
  import mmrp_pkg::*;
  localparam int WBW = $clog2(WB_WORDS);

  mmrp_fstate_t st_q;
  logic [1:0] ws_q, cnt_q;
  logic irqen_q, locke_q, cmde_q, fill_q, demand_q;
  logic [15:0] lock_q;
  logic [AW-1:0] tag_q [2];
  logic [31:0] dat_q [2];
  logic [1:0] vld_q;
  logic [31:0] wbuf [WB_WORDS];

  // Request decode; ack blocks the still-held request for one cycle
  wire take = acc_req & ~acc_ack & (st_q == F_IDLE);
  wire [AW-1:0] w = acc_addr[AW+1:2];
  wire hit0 = vld_q[0] & (tag_q[0] == w);
  wire hit1 = vld_q[1] & (tag_q[1] == w);
  wire hit = hit0 | hit1;
  wire [AW-1:0] w_next = w + 1'b1;
  wire nxt_in = (vld_q[~hit1] & (tag_q[~hit1] == w_next));
  wire [AW-1:0] a_next = arr_addr + 1'b1;

  // Command decode
  wire [3:0] cmd = cfg_wdata[3:0];
  wire [9:0] pg = cfg_wdata[`MMRP_FCR_PAGE_LSB+9:`MMRP_FCR_PAGE_LSB];
  wire lockable = (pg[9:8] == 2'b00);
  wire [3:0] region = pg[7:4];
  wire prog_lock = lockable & lock_q[region];
  wire is_prog = (cmd == FC_PROG);
  wire is_erase = (cmd == FC_ERASE);
  wire is_set = (cmd == FC_SETLOCK);
  wire is_clr = (cmd == FC_CLRLOCK);
  wire lock_err = (is_prog & prog_lock) | (is_erase & (|lock_q));
  wire cmd_err = ~(is_prog | is_erase | is_set | is_clr)
               | ((is_set | is_clr) & ~lockable);

  assign fmr_val = {29'h0, irqen_q, ws_q};
  assign fsr_val = {lock_q, 12'h0, cmde_q, locke_q, 1'b0, 1'b1};

  // Read path: wait states, dual prefetch words, write buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= F_IDLE;
      cnt_q <= 2'h0;
      fill_q <= 1'b0;
      demand_q <= 1'b0;
      vld_q <= 2'b00;
      acc_ack <= 1'b0;
      acc_rdata <= `MMRP_RST_WORD;
      rd_en <= 1'b0;
      arr_addr <= '0;
      standby <= 1'b1;
    end else begin
      acc_ack <= 1'b0;
      standby <= (st_q == F_IDLE) & ~take; // [R15]
      case (st_q)
        F_IDLE: begin
          if (take && acc_write) begin
            acc_ack <= 1'b1; // [R14]
          end else if (take && hit) begin
            acc_ack <= 1'b1;
            acc_rdata <= hit1 ? dat_q[1] : dat_q[0]; // [R13]
            if (!nxt_in) begin
              rd_en <= 1'b1;
              arr_addr <= w_next;
              fill_q <= ~hit1;
              cnt_q <= ws_q;
              demand_q <= 1'b0;
              st_q <= F_FETCH;
            end
          end else if (take) begin
            rd_en <= 1'b1;
            arr_addr <= w;
            fill_q <= ~fill_q;
            cnt_q <= ws_q; // [R12]
            demand_q <= 1'b1;
            st_q <= F_FETCH;
          end
        end
        F_FETCH: begin
          if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
          end else begin
            vld_q[fill_q] <= 1'b1;
            if (demand_q) begin
              // Anticipate the next sequential word into the other slot
              acc_ack <= 1'b1;
              acc_rdata <= arr_rdata;
              arr_addr <= a_next; // [R13]
              fill_q <= ~fill_q;
              cnt_q <= ws_q;
              demand_q <= 1'b0;
            end else begin
              rd_en <= 1'b0;
              st_q <= F_IDLE;
            end
          end
        end
        default: st_q <= F_IDLE;
      endcase
    end
  end

  // Prefetch word storage and write buffer, no reset needed
  always_ff @(posedge clk) begin
    if (st_q == F_FETCH && cnt_q == 2'h0) begin
      tag_q[fill_q] <= arr_addr;
      dat_q[fill_q] <= arr_rdata;
    end
    if (take && acc_write) begin
      wbuf[acc_addr[WBW+1:2]] <= acc_wdata; // [R14]
    end
    wb_data <= wbuf[wb_idx];
  end

  // Mode, lock bits, command outcome and error interrupt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {irqen_q, ws_q} <= `MMRP_RST_FMR;
      lock_q <= `MMRP_RST_LOCKS;
      locke_q <= 1'b0;
      cmde_q <= 1'b0;
      prog <= 1'b0;
      erase <= 1'b0;
      page <= 10'h000;
      irq <= 1'b0;
    end else begin
      prog <= fcr_wr & is_prog & ~prog_lock; // [R18]
      erase <= fcr_wr & is_erase & ~(|lock_q); // [R18]
      irq <= irqen_q & (locke_q | cmde_q); // [R19]
      if (fmr_wr) begin
        ws_q <= cfg_wdata[`MMRP_FMR_WS_LSB+1:`MMRP_FMR_WS_LSB];
        irqen_q <= cfg_wdata[`MMRP_FMR_IRQEN];
      end
      if (fcr_wr) begin
        page <= pg;
        locke_q <= lock_err; // [R19]
        cmde_q <= cmd_err;
        if (is_set && lockable) lock_q[region] <= 1'b1; // [R16] [R17]
        if (is_clr && lockable) lock_q[region] <= 1'b0; // [R17]
      end
    end
  end
endmodule : mmrp_flash_seq
`default_nettype wire

// ===== core/mmrp_pkg.sv
package mmrp_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10, SZ_BAD = 2'b11
  } mmrp_size_t;
  typedef enum logic [1:0] {
    AB_NONE = 2'b00, AB_MISALIGN = 2'b01, AB_UNMAPPED = 2'b10,
    AB_PROTECT = 2'b11
  } mmrp_abort_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_CHECK = 2'b01, S_WAIT = 2'b10, S_RESP = 2'b11
  } mmrp_state_t;
  typedef enum logic [1:0] {
    F_IDLE = 2'b00, F_FETCH = 2'b01
  } mmrp_fstate_t;
  typedef enum logic [3:0] {
    FC_PROG = 4'h1, FC_SETLOCK = 4'h2, FC_CLRLOCK = 4'h4, FC_ERASE = 4'h8
  } mmrp_fcmd_t;
endpackage : mmrp_pkg

// ===== core/mmrp_top.sv
// Function
// R1: SRAM only at its base before remap
// R2: After remap SRAM also appears at zero
// R3: Flash at its base, aliased at zero pre-remap
// R4: Selects for three 1MB areas, one 256MB
// R5: System peripherals in top 4KB, 512B slots
// R6: Misaligned data access aborts the master
// R7: Abort source, type, attributes captured
// R8: Sixteen protection areas, 1KB to 1MB each
// R9: Per area write and/or user denial
// R10: Peripheral space write and/or user denial
// R11: Arbiter grants processor or DMA master
// R12: Zero to three flash read wait states
// R13: Two prefetch words speed sequential fetches
// R14: 256-byte page write buffer, word interface
// R15: Flash idle puts array in standby
// R16: Sixteen lock bits over lowest 64KB
// R17: Lock bits change only by commands
// R18: Locked region refuses erase and program
// R19: Forbidden flash command raises interrupt
// R20: Unmapped access aborts and is recorded
`timescale 1ns/1ps
`default_nettype none
`include "mmrp_cfg.svh"

module mmrp_top #(
  parameter int NUM_AREAS = 16,
  parameter int FL_AW = 16,
  parameter int WB_WORDS = 64
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // APB register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Processor core master
  input wire logic CPU_REQ,
  input wire logic [31:0] CPU_ADDR,
  input wire logic CPU_WRITE,
  input wire mmrp_pkg::mmrp_size_t CPU_SIZE,
  input wire logic CPU_USER,
  input wire logic [31:0] CPU_WDATA,
  output logic CPU_DONE,
  output logic CPU_ABORT,
  output logic [31:0] CPU_RDATA,
  // Peripheral DMA master, always privileged
  input wire logic DMA_REQ,
  input wire logic [31:0] DMA_ADDR,
  input wire logic DMA_WRITE,
  input wire mmrp_pkg::mmrp_size_t DMA_SIZE,
  input wire logic [31:0] DMA_WDATA,
  output logic DMA_DONE,
  output logic DMA_ABORT,
  output logic [31:0] DMA_RDATA,
  // Downstream SRAM and peripheral path
  output logic BUS_VALID,
  output logic [31:0] BUS_ADDR,
  output logic BUS_WRITE,
  output var mmrp_pkg::mmrp_size_t BUS_SIZE,
  output logic [31:0] BUS_WDATA,
  output logic BUS_SEL_SRAM,
  output logic BUS_SEL_PERIPH,
  output logic BUS_SEL_SYS,
  output logic [2:0] BUS_SYS_SLOT,
  input wire logic BUS_READY,
  input wire logic [31:0] BUS_RDATA,
  // Flash array
  output logic FL_RD_EN,
  output logic [FL_AW-1:0] FL_ADDR,
  input wire logic [31:0] FL_RDATA,
  output logic FL_STANDBY,
  output logic FL_PROG,
  output logic FL_ERASE,
  output logic [9:0] FL_PAGE,
  input wire logic [$clog2(WB_WORDS)-1:0] FL_WB_IDX,
  output logic [31:0] FL_WB_DATA,
  output logic FLASH_IRQ
);
  import mmrp_pkg::*;

  // Misalignment against access size; reserved size always aborts
  function automatic logic misaligned(input mmrp_size_t sz,
                                      input logic [1:0] a);
    misaligned = (sz == SZ_BAD) || (sz == SZ_HALF && a[0])
               || (sz == SZ_WORD && a != 2'b00);
  endfunction : misaligned

  // Protection area match, size code 0 is 1KB up to 10 for 1MB
  function automatic logic area_hit(input logic [31:0] cfg,
                                    input logic [31:0] a);
    logic [3:0] code;
    logic [31:0] mask;
    code = cfg[`MMRP_PR_SZ_LSB+3:`MMRP_PR_SZ_LSB];
    if (code > `MMRP_PR_SZ_MAX) code = `MMRP_PR_SZ_MAX;
    mask = `MMRP_PR_MIN_MASK << code;
    area_hit = cfg[`MMRP_PR_EN] && ((a & mask) == (cfg & mask));
  endfunction : area_hit

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  wire rst_n = rst_sync_q[1];

  mmrp_state_t st_q;
  logic src_q, wr_q, user_q, remap_q, fl_req_q, fl_path_q;
  logic [31:0] addr_q, wdata_q, aasr_q;
  mmrp_size_t size_q;
  logic [7:0] asr_q;
  logic [2:0] ppr_q;
  logic [31:0] mpu_q [NUM_AREAS];
  logic fl_ack;
  logic [31:0] fl_rdata, fmr_val, fsr_val;

  // APB decode; zero-wait slave, so the access phase always completes
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr = PSEL & PENABLE & PWRITE & PREADY;
  wire hit_remap = (PADDR == `MMRP_OFF_REMAP);
  wire hit_asr = (PADDR == `MMRP_OFF_ASR);
  wire hit_aasr = (PADDR == `MMRP_OFF_AASR);
  wire hit_ppr = (PADDR == `MMRP_OFF_PPR);
  wire hit_fmr = (PADDR == `MMRP_OFF_FMR);
  wire hit_fcr = (PADDR == `MMRP_OFF_FCR);
  wire hit_fsr = (PADDR == `MMRP_OFF_FSR);
  wire hit_mpu = ((PADDR & `MMRP_MPU_WIN_MASK) == `MMRP_OFF_MPU)
               && (PADDR[1:0] == 2'b00);
  wire [3:0] mpu_idx = PADDR[5:2];
  wire apb_hit = hit_remap | hit_asr | hit_aasr | hit_ppr | hit_fmr
               | hit_fcr | hit_fsr | hit_mpu;
  wire [31:0] rd_mux =
      hit_remap ? {31'h0, remap_q} :
      hit_asr ? {24'h0, asr_q} :
      hit_aasr ? aasr_q :
      hit_ppr ? {29'h0, ppr_q} :
      hit_fmr ? fmr_val :
      hit_fsr ? fsr_val :
      hit_mpu ? mpu_q[mpu_idx] : `MMRP_RST_WORD;

  // Address decode of the granted request
  wire [11:0] mb = addr_q[31:20];
  wire in_alias = (mb == `MMRP_MB_ALIAS);
  wire sel_sram = (mb == `MMRP_MB_SRAM) | (in_alias & remap_q); // [R1] [R2]
  wire sel_flash = (mb == `MMRP_MB_FLASH) | (in_alias & ~remap_q); // [R3]
  wire sel_periph = (addr_q[31:28] == `MMRP_PERIPH_NIB); // [R4]
  wire sel_sys = (addr_q[31:12] == `MMRP_SYS_PAGE); // [R5]
  wire [2:0] sys_slot = addr_q[`MMRP_SYS_SLOT_LSB+2:`MMRP_SYS_SLOT_LSB];
  wire unmapped = ~(sel_sram | sel_flash | sel_periph); // [R20]
  wire mis = misaligned(size_q, addr_q[1:0]); // [R6]
  wire [31:0] phys = in_alias
      ? {(remap_q ? `MMRP_MB_SRAM : `MMRP_MB_FLASH), addr_q[19:0]}
      : addr_q;

  // Protection area scan; any enabled matching area may deny
  logic mpu_deny;
  always_comb begin
    mpu_deny = 1'b0;
    for (int i = 0; i < NUM_AREAS; i++) begin
      if (area_hit(mpu_q[i], addr_q)) begin // [R8]
        mpu_deny = mpu_deny | (mpu_q[i][`MMRP_PR_WDENY] & wr_q)
                 | (mpu_q[i][`MMRP_PR_UDENY] & user_q); // [R9]
      end
    end
  end
  wire per_deny = sel_periph & ((ppr_q[`MMRP_PR_WDENY] & wr_q)
                | (ppr_q[`MMRP_PR_UDENY] & user_q)); // [R10]
  wire abort = mis | unmapped | mpu_deny | per_deny;
  wire [1:0] ab_type = mis ? AB_MISALIGN
                     : unmapped ? AB_UNMAPPED : AB_PROTECT;
  wire ab_now = (st_q == S_CHECK) & abort;
  wire asr_clr = apb_wr & hit_asr;

  // Completion of a granted access on either path
  wire fin_bus = (st_q == S_WAIT) & ~fl_path_q & BUS_READY;
  wire fin_fl = (st_q == S_WAIT) & fl_path_q & fl_ack;
  wire finish = ab_now | fin_bus | fin_fl;
  wire [31:0] resp_data = fin_fl ? fl_rdata
                        : fin_bus ? BUS_RDATA : `MMRP_RST_WORD;

  // APB registers, answer prepared in the setup phase
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= `MMRP_RST_WORD;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      remap_q <= 1'b0;
      ppr_q <= 3'h0;
      for (int i = 0; i < NUM_AREAS; i++) mpu_q[i] <= `MMRP_RST_WORD;
    end else begin
      PREADY <= 1'b1;
      if (apb_setup) begin
        PRDATA <= PWRITE ? `MMRP_RST_WORD : rd_mux;
        PSLVERR <= ~apb_hit;
      end
      if (apb_wr && hit_remap && PWDATA[0]) remap_q <= ~remap_q; // [R2]
      if (apb_wr && hit_ppr) ppr_q <= PWDATA[2:0] & 3'h7; // [R10]
      if (apb_wr && hit_mpu) mpu_q[mpu_idx] <= PWDATA & `MMRP_PR_MASK;
    end
  end

  // Abort capture; a new abort wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      asr_q <= 8'h00;
      aasr_q <= `MMRP_RST_WORD;
    end else if (ab_now) begin
      asr_q <= {user_q, wr_q, size_q, ab_type, src_q, 1'b1}; // [R7] [R20]
      aasr_q <= addr_q; // [R7]
    end else if (asr_clr) begin
      asr_q[`MMRP_ASR_VALID] <= 1'b0;
    end
  end

  // Arbiter and access sequencer
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      src_q <= 1'b0;
      addr_q <= `MMRP_RST_WORD;
      wr_q <= 1'b0;
      user_q <= 1'b0;
      size_q <= SZ_BYTE;
      wdata_q <= `MMRP_RST_WORD;
      fl_path_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          // DMA first: its transfers are short and latency bound
          if (DMA_REQ || CPU_REQ) begin
            src_q <= DMA_REQ; // [R11]
            addr_q <= DMA_REQ ? DMA_ADDR : CPU_ADDR;
            wr_q <= DMA_REQ ? DMA_WRITE : CPU_WRITE;
            size_q <= DMA_REQ ? DMA_SIZE : CPU_SIZE;
            user_q <= DMA_REQ ? 1'b0 : CPU_USER;
            wdata_q <= DMA_REQ ? DMA_WDATA : CPU_WDATA;
            st_q <= S_CHECK;
          end
        end
        S_CHECK: begin
          fl_path_q <= sel_flash;
          st_q <= abort ? S_RESP : S_WAIT; // [R6]
        end
        S_WAIT: if (finish) st_q <= S_RESP;
        S_RESP: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Downstream request, held until the slave answers
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUS_VALID <= 1'b0;
      BUS_ADDR <= `MMRP_RST_WORD;
      BUS_WRITE <= 1'b0;
      BUS_SIZE <= SZ_BYTE;
      BUS_WDATA <= `MMRP_RST_WORD;
      BUS_SEL_SRAM <= 1'b0;
      BUS_SEL_PERIPH <= 1'b0;
      BUS_SEL_SYS <= 1'b0;
      BUS_SYS_SLOT <= 3'h0;
      fl_req_q <= 1'b0;
    end else if (st_q == S_CHECK && !abort) begin
      BUS_VALID <= ~sel_flash;
      BUS_ADDR <= phys; // [R1] [R2]
      BUS_WRITE <= wr_q;
      BUS_SIZE <= size_q;
      BUS_WDATA <= wdata_q;
      BUS_SEL_SRAM <= sel_sram; // [R4]
      BUS_SEL_PERIPH <= sel_periph; // [R4]
      BUS_SEL_SYS <= sel_sys; // [R5]
      BUS_SYS_SLOT <= sys_slot; // [R5]
      fl_req_q <= sel_flash; // [R3]
    end else if (finish) begin
      BUS_VALID <= 1'b0;
      BUS_SEL_SRAM <= 1'b0;
      BUS_SEL_PERIPH <= 1'b0;
      BUS_SEL_SYS <= 1'b0;
      fl_req_q <= 1'b0;
    end
  end

  // Answer to the granted master, one-cycle done pulse
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CPU_DONE <= 1'b0;
      CPU_ABORT <= 1'b0;
      CPU_RDATA <= `MMRP_RST_WORD;
      DMA_DONE <= 1'b0;
      DMA_ABORT <= 1'b0;
      DMA_RDATA <= `MMRP_RST_WORD;
    end else begin
      CPU_DONE <= finish & ~src_q;
      DMA_DONE <= finish & src_q;
      if (finish && !src_q) begin
        CPU_ABORT <= ab_now; // [R6] [R20]
        CPU_RDATA <= resp_data;
      end
      if (finish && src_q) begin
        DMA_ABORT <= ab_now; // [R6] [R20]
        DMA_RDATA <= resp_data;
      end
    end
  end

  // Flash sequencer with prefetch, lock bits and write buffer
  mmrp_flash_seq #(
    .AW(FL_AW),
    .WB_WORDS(WB_WORDS)
  ) u_embedded_flash_sequencer (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .acc_req(fl_req_q),
    .acc_write(wr_q),
    .acc_addr(addr_q),
    .acc_wdata(wdata_q),
    .acc_ack(fl_ack),
    .acc_rdata(fl_rdata),
    .fmr_wr(apb_wr & hit_fmr), // [R12]
    .fcr_wr(apb_wr & hit_fcr), // [R17]
    .cfg_wdata(PWDATA),
    .fmr_val(fmr_val),
    .fsr_val(fsr_val),
    .irq(FLASH_IRQ),
    .rd_en(FL_RD_EN),
    .arr_addr(FL_ADDR),
    .arr_rdata(FL_RDATA),
    .standby(FL_STANDBY),
    .prog(FL_PROG),
    .erase(FL_ERASE),
    .page(FL_PAGE),
    .wb_idx(FL_WB_IDX),
    .wb_data(FL_WB_DATA)
  );
endmodule : mmrp_top
`default_nettype wire

// ===== verification/memory_map_remap_protect_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmrp_cfg.svh"
module memory_map_remap_protect_bench;
  import mmrp_pkg::*;
  localparam logic N = 1'b0;
  localparam logic Y = 1'b1;
  localparam logic [31:0] Z = 32'h0;
  localparam logic [11:0] ASR = `MMRP_OFF_ASR, FSR = `MMRP_OFF_FSR;
  localparam logic [11:0] FCR = `MMRP_OFF_FCR;
  logic SYS_CLK = '0, ARST_N = '0, PSEL = '0, PENABLE = '0;
  logic PWRITE = '0, CPU_REQ = '0, CPU_WRITE = '0, CPU_USER = '0;
  logic DMA_REQ = '0, DMA_WRITE = '0, slow = '0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = Z, CPU_ADDR = Z, CPU_WDATA = Z, DMA_ADDR = Z;
  logic [31:0] DMA_WDATA = Z, PRDATA, CPU_RDATA, DMA_RDATA, BUS_ADDR;
  logic [31:0] BUS_WDATA, BUS_RDATA, FL_RDATA, FL_WB_DATA, rd;
  mmrp_size_t CPU_SIZE = SZ_WORD, DMA_SIZE = SZ_WORD, BUS_SIZE;
  logic [5:0] FL_WB_IDX = 6'h0;
  logic PREADY, PSLVERR, CPU_DONE, CPU_ABORT, DMA_DONE, DMA_ABORT, ab, er;
  logic BUS_VALID, BUS_WRITE, BUS_SEL_SRAM, BUS_SEL_PERIPH, BUS_SEL_SYS;
  logic BUS_READY, FL_RD_EN, FL_STANDBY, FL_PROG, FL_ERASE, FLASH_IRQ;
  logic [2:0] BUS_SYS_SLOT;
  logic [15:0] FL_ADDR;
  logic [9:0] FL_PAGE;
  int num_errors = 0, cmp_count = 0, cyc = 0, n_prog = 0, n_erase = 0;
  mmrp_top u_dut (.*);
  mmrp_mem_model u_mem (.clk(SYS_CLK), .slow(slow), .valid(BUS_VALID),
    .addr(BUS_ADDR), .ready(BUS_READY), .rdata(BUS_RDATA), .fl_en(FL_RD_EN),
    .fl_addr(FL_ADDR), .fl_rdata(FL_RDATA));
  always #4 SYS_CLK = ~SYS_CLK;
  // Pulse counters and hang guard
  always @(posedge SYS_CLK) begin
    cyc++;
    if (FL_PROG === 1'b1) n_prog++;
    if (FL_ERASE === 1'b1) n_erase++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic tick;
    @(posedge SYS_CLK);
  endtask : tick
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask : cmp
  function automatic logic [31:0] fl(input logic [31:0] a);
    return {16'hA5A5, a[17:2]};
  endfunction : fl
  // APB cycle; data taken at the ready edge
  task automatic apb(input logic [11:0] a, input logic [31:0] d,
                     input logic w = Y);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    tick();
    PENABLE <= 1'b1;
    tick();
    while (PREADY !== 1'b1) tick();
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    tick();
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic ee = N);
    apb(a, Z, N);
    cmp(rd, e);
    cmp(32'(er), 32'(ee));
  endtask : rchk
  // Master access, same fields to both
  task automatic acc(input logic [31:0] a, input logic [31:0] erd,
    input logic eab = N, input logic w = N, input mmrp_size_t s = SZ_WORD,
    input logic u = N, input logic [31:0] wd = Z, input logic d = N);
    CPU_REQ <= !d;
    DMA_REQ <= d;
    CPU_ADDR <= a;
    DMA_ADDR <= a;
    CPU_WRITE <= w;
    DMA_WRITE <= w;
    CPU_SIZE <= s;
    DMA_SIZE <= s;
    CPU_WDATA <= wd;
    DMA_WDATA <= wd;
    CPU_USER <= u;
    tick();
    while ((d ? DMA_DONE : CPU_DONE) !== 1'b1) tick();
    rd = d ? DMA_RDATA : CPU_RDATA;
    ab = d ? DMA_ABORT : CPU_ABORT;
    CPU_REQ <= 1'b0;
    DMA_REQ <= 1'b0;
    tick();
    cmp(32'(ab), 32'(eab));
    if (!eab && !w) cmp(rd, erd);
  endtask : acc
  initial begin
    repeat (4) tick();
    ARST_N <= 1'b1;
    repeat (3) tick();
    // Reset state, unmapped offset
    rchk(`MMRP_OFF_REMAP, Z);
    rchk(FSR, 32'h1);
    rchk(`MMRP_OFF_FMR, Z);
    rchk(12'h01C, Z, Y);
    // Flash at zero before remap
    acc(32'h0, fl(Z));
    acc(32'h100008, fl(32'h8));
    acc(32'h10000C, fl(32'hC));
    acc(32'h200010, ~32'h200010);
    apb(`MMRP_OFF_REMAP, 32'h1);
    rchk(`MMRP_OFF_REMAP, 32'h1);
    acc(32'h10, ~32'h200010);
    acc(32'h100010, fl(32'h10));
    apb(`MMRP_OFF_FMR, 32'h3);
    acc(32'h100040, fl(32'h40));
    // Alignment, reserved size, capture
    acc(32'h200002, Z, Y);
    rchk(ASR, 32'h25);
    rchk(`MMRP_OFF_AASR, 32'h200002);
    acc(32'h200001, Z, Y, N, SZ_HALF);
    acc(32'h200000, Z, Y, N, SZ_BAD);
    acc(32'h200003, ~32'h200003, N, N, SZ_BYTE);
    acc(32'h300000, Z, Y, Y, SZ_WORD, N, 32'h1234, Y);
    rchk(ASR, 32'h6B);
    // Clear drops only the valid bit
    apb(ASR, Z);
    rchk(ASR, 32'h6A);
    // Area 0: 1 KB write deny; area 1: 4 KB user deny
    apb(`MMRP_OFF_MPU, 32'h200003);
    apb(`MMRP_OFF_MPU + 12'h4, 32'h208025);
    acc(32'h2003FC, Z, Y, Y);
    rchk(ASR, 32'h6D);
    acc(32'h200400, Z, N, Y);
    acc(32'h2003FC, ~32'h2003FC);
    acc(32'h208FFC, Z, Y, N, SZ_WORD, Y);
    acc(32'h209000, ~32'h209000, N, N, SZ_WORD, Y);
    // Peripheral protection, system slots
    apb(`MMRP_OFF_PPR, 32'h4);
    acc(32'hFFFFF200, Z, Y, N, SZ_WORD, Y);
    acc(32'hFFFFF200, ~32'hFFFFF200);
    apb(`MMRP_OFF_PPR, 32'h2);
    acc(32'hF0000100, Z, Y, Y);
    acc(32'hF0000100, ~32'hF0000100);
    // Both masters reading, slave stalling
    slow <= 1'b1;
    CPU_REQ <= 1'b1;
    DMA_REQ <= 1'b1;
    tick();
    while ((CPU_DONE | DMA_DONE) !== 1'b1) tick();
    cmp(32'(DMA_DONE), 32'h1);
    DMA_REQ <= 1'b0;
    tick();
    while (CPU_DONE !== 1'b1) tick();
    cmp(CPU_RDATA, ~32'hF0000100);
    CPU_REQ <= 1'b0;
    slow <= 1'b0;
    tick();
    // Write buffer readback, then standby
    acc(32'h100004, Z, N, Y, SZ_WORD, N, 32'hCAFE_0001);
    FL_WB_IDX <= 6'h01;
    repeat (2) tick();
    cmp(FL_WB_DATA, 32'hCAFE_0001);
    cmp(32'(FL_STANDBY), 32'h1);
    // Lock region 0 via page 15, refuse, unlock, erase
    apb(`MMRP_OFF_FMR, 32'h4);
    apb(FCR, 32'hF02);
    rchk(FSR, 32'h10001);
    apb(FCR, 32'h1);
    rchk(FSR, 32'h10005);
    cmp(32'(FLASH_IRQ), 32'h1);
    apb(FCR, 32'h1001);
    rchk(FSR, 32'h10001);
    cmp(32'(FLASH_IRQ), Z);
    apb(FCR, 32'h8);
    cmp(32'(n_erase), Z);
    apb(FCR, 32'h104);
    apb(FCR, 32'h8);
    rchk(FSR, 32'h1);
    cmp(32'(n_prog) << 4 | 32'(n_erase), 32'h11);
    apb(FCR, 32'h10002);
    rchk(FSR, 32'h9);
    complete_run();
  end
endmodule : memory_map_remap_protect_bench
`default_nettype wire

// ===== verification/mmrp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmrp_mem_model (
  // Clock and pacing
  input wire logic clk,
  input wire logic slow,
  // SRAM and peripheral slave
  input wire logic valid,
  input wire logic [31:0] addr,
  output logic ready,
  output logic [31:0] rdata,
  // Flash array
  input wire logic fl_en,
  input wire logic [15:0] fl_addr,
  output logic [31:0] fl_rdata
);
  logic [1:0] wait_q = 2'h0;
  logic [31:0] junk_q = 32'h0;
  // Slow mode stalls two cycles; junk changes every cycle
  always @(posedge clk) begin
    junk_q <= ~junk_q ^ 32'h1;
    if (!valid) wait_q <= 2'h0;
    else if (wait_q != 2'h3) wait_q <= wait_q + 2'h1;
  end
  assign ready = valid && (!slow || wait_q == 2'h2);
  // Unselected lines show junk, never the last value
  assign rdata = valid ? ~addr : junk_q;
  assign fl_rdata = fl_en ? {16'hA5A5, fl_addr} : junk_q;
endmodule : mmrp_mem_model
`default_nettype wire

// ===== verification/mmrp_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mmrp_mon (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // Masters
  input wire logic CPU_DONE,
  input wire logic CPU_ABORT,
  input wire logic [31:0] CPU_ADDR,
  input wire mmrp_pkg::mmrp_size_t CPU_SIZE,
  input wire logic DMA_DONE,
  // Downstream path
  input wire logic BUS_VALID,
  input wire logic [31:0] BUS_ADDR,
  input wire logic BUS_SEL_SRAM,
  input wire logic BUS_SEL_PERIPH,
  input wire logic BUS_SEL_SYS,
  input wire logic [2:0] BUS_SYS_SLOT,
  input wire logic BUS_READY,
  // Flash
  input wire logic FL_RD_EN,
  input wire logic FL_STANDBY,
  input wire logic FLASH_IRQ
);
  import mmrp_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // Address held at completion, so decode it then
  wire mis = (CPU_SIZE == SZ_WORD && CPU_ADDR[1:0] != 2'h0) ||
             (CPU_SIZE == SZ_HALF && CPU_ADDR[0]);
  wire hole = CPU_ADDR[31:28] != 4'hF && CPU_ADDR[31:20] > 12'h002;
  chk_misalign_abort: assert property (CPU_DONE && mis |-> CPU_ABORT)
    else $error("no misalign abort");
  chk_hole_abort: assert property (CPU_DONE && hole |-> CPU_ABORT)
    else $error("no unmapped abort");
  chk_sram_phys: assert property (BUS_VALID && BUS_SEL_SRAM |->
    BUS_ADDR[31:20] == 12'h002) else $error("sram off base");
  chk_periph_area: assert property (BUS_VALID && BUS_SEL_PERIPH |->
    BUS_ADDR[31:28] == 4'hF) else $error("periph off area");
  chk_sys_slot: assert property (BUS_VALID && BUS_SEL_SYS |->
    BUS_ADDR[31:12] == 20'hFFFFF && BUS_SYS_SLOT == BUS_ADDR[11:9])
    else $error("bad sys slot");
  chk_bus_hold: assert property (BUS_VALID && !BUS_READY |=>
    BUS_VALID && $stable(BUS_ADDR)) else $error("req not held");
  chk_done_after: assert property (BUS_VALID && BUS_READY |=>
    !BUS_VALID && (CPU_DONE || DMA_DONE)) else $error("done late");
  chk_one_grant: assert property (!(CPU_DONE && DMA_DONE))
    else $error("two dones");
  chk_standby_idle: assert property (FL_RD_EN |-> !FL_STANDBY)
    else $error("read in standby");
  cov_abort: cover property (CPU_DONE && CPU_ABORT);
  cov_sys: cover property (BUS_VALID && BUS_SEL_SYS);
  cov_irq: cover property ($rose(FLASH_IRQ));
endmodule : mmrp_mon
bind mmrp_top mmrp_mon u_mon (.SYS_CLK, .ARST_N, .CPU_DONE, .CPU_ABORT,
  .CPU_ADDR, .CPU_SIZE, .DMA_DONE, .BUS_VALID, .BUS_ADDR, .BUS_SEL_SRAM,
  .BUS_SEL_PERIPH, .BUS_SEL_SYS, .BUS_SYS_SLOT, .BUS_READY, .FL_RD_EN,
  .FL_STANDBY, .FLASH_IRQ);
`default_nettype wire
